/* File: lsnc_pkg.sv */
// Purpose : constants shared by the lock status and nvm control register bank
// Assumes : byte-wide register port with 16-bit addresses
// Notes   : channel blocks repeat at a fixed stride above channel zero
package lsnc_pkg;

    localparam int          LSNC_AW            = 16;
    localparam int          LSNC_DW            = 8;
    localparam int          LSNC_NCH           = 4;
    localparam int          LSNC_LVW           = 12;
    localparam int          LSNC_SEQ_LEN       = 82;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [15:0] LSNC_UPDATE_ADDR   = 16'h000F;
    localparam logic [7:0]  LSNC_UPDATE_VALUE  = 8'h01;
    localparam logic [15:0] LSNC_PH_LOW_ADDR   = 16'h0D27;
    localparam logic [15:0] LSNC_PH_HIGH_ADDR  = 16'h0D28;
    localparam logic [15:0] LSNC_FR_LOW_ADDR   = 16'h0D29;
    localparam logic [15:0] LSNC_FR_HIGH_ADDR  = 16'h0D2A;
    localparam logic [15:0] LSNC_CH_STRIDE     = 16'h0020;
    localparam logic [15:0] LSNC_NVM_CTRL_ADDR = 16'h0E00;
    localparam logic [15:0] LSNC_NVM_COND_ADDR = 16'h0E01;
    localparam logic [15:0] LSNC_NVM_SAVE_ADDR = 16'h0E02;
    localparam logic [15:0] LSNC_NVM_LOAD_ADDR = 16'h0E03;
    localparam logic [15:0] LSNC_EVT_STAT_ADDR = 16'h0E04;
    localparam logic [15:0] LSNC_EVT_MASK_ADDR = 16'h0E05;
    localparam logic [15:0] LSNC_SEQ_FIRST     = 16'h0E10;
    localparam logic [15:0] LSNC_SEQ_LAST      = 16'h0E61;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int          LSNC_WREN_BIT      = 0;
    localparam int          LSNC_FAST_BIT      = 1;
    localparam int          LSNC_TRIG_BIT      = 0;
    localparam int          LSNC_EV_SAVE_DONE  = 0;
    localparam int          LSNC_EV_LOAD_DONE  = 1;
    localparam int          LSNC_EV_SAVE_DENY  = 2;
    localparam int          LSNC_EV_SNAPSHOT   = 3;
    localparam int          LSNC_NEV           = 4;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [1:0]  LSNC_CTRL_RESET    = 2'h0;
    localparam logic [3:0]  LSNC_COND_RESET    = 4'h0;
    localparam logic [11:0] LSNC_LEVEL_RESET   = 12'h000;
    localparam logic [3:0]  LSNC_MASK_RESET    = 4'h0;

    // default storage sequence: stores every register
    function automatic logic [7:0] lsnc_seq_default(input logic [6:0] idx);
        case (idx)
            7'h00:   return 8'h98;
            7'h01:   return 8'h01;
            7'h02:   return 8'h00;
            7'h03:   return 8'hFE;
            7'h04:   return 8'h1F;
            7'h05:   return 8'h01;
            7'h06:   return 8'h00;
            7'h07:   return 8'h08;
            7'h08:   return 8'h02;
            7'h09:   return 8'h00;
            7'h0A:   return 8'h80;
            7'h0B:   return 8'h91;
            default: return 8'h00;
        endcase
    endfunction

endpackage

/* File: lsnc_regs.sv */
// Purpose : lock detector level readback for four loops and nvm control registers
// Assumes : level inputs and nvm engine handshakes are on mclk; byte register port
// Notes   : rdata is valid only in the cycle after rd
`timescale 1ns/1ps
module lsnc_regs
    import lsnc_pkg::*;
(
    input  wire logic                             mclk,
    input  wire logic                             rst,
    input  wire logic [LSNC_AW-1:0]               addr,
    input  wire logic [LSNC_DW-1:0]               wdata,
    input  wire logic                             wr,
    input  wire logic                             rd,
    output logic      [LSNC_DW-1:0]               rdata,
    input  wire logic [LSNC_NCH-1:0][LSNC_LVW-1:0] phase_level,
    input  wire logic [LSNC_NCH-1:0][LSNC_LVW-1:0] freq_level,
    output logic                                  nvm_fast_mode,
    output logic                                  nvm_write_en,
    output logic      [3:0]                       nvm_condition,
    output logic                                  nvm_cond_override,
    output logic                                  nvm_save_start,
    output logic                                  nvm_load_start,
    input  wire logic                             nvm_save_done,
    input  wire logic                             nvm_load_done,
    input  wire logic [6:0]                       seq_index,
    output logic      [7:0]                       seq_byte,
    output logic                                  irq
);

    typedef struct packed {
        logic [LSNC_NCH-1:0][LSNC_LVW-1:0] ph_snap;
        logic [LSNC_NCH-1:0][LSNC_LVW-1:0] fr_snap;
        logic                              fast;
        logic                              wren;
        logic [3:0]                        cond;
        logic                              ovr;
        logic                              save_pend;
        logic                              load_pend;
        logic                              save_go;
        logic                              load_go;
        logic [LSNC_SEQ_LEN-1:0][7:0]      seq;
        logic [LSNC_NEV-1:0]               evt;
        logic [LSNC_NEV-1:0]               mask;
        logic [7:0]                        rdata;
        logic [7:0]                        seq_byte;
        logic                              irq;
    } lsnc_state_t;

    lsnc_state_t st;
    lsnc_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    // {hit, channel, field}: field 0..3 = phase low, phase high, freq low, freq high
    function automatic logic [4:0] lsnc_chan_decode(input logic [15:0] a);
        logic [15:0] rel;
        logic [4:0]  res;
        res = 5'h00;
        rel = 16'h0000;
        for (int c = 0; c < LSNC_NCH; c++) begin
            rel = a - 16'(c) * LSNC_CH_STRIDE;
            if (rel >= LSNC_PH_LOW_ADDR && rel <= LSNC_FR_HIGH_ADDR) begin
                res = {1'b1, 2'(c), 2'(rel - LSNC_PH_LOW_ADDR)};
            end
        end
        return res;
    endfunction

    function automatic logic lsnc_in_seq(input logic [15:0] a);
        return (a >= LSNC_SEQ_FIRST) && (a <= LSNC_SEQ_LAST);
    endfunction

    logic [4:0]          ch_dec;
    logic [LSNC_NCH-1:0][7:0] ch_byte;
    logic [6:0]          seq_off;

    assign ch_dec  = lsnc_chan_decode(addr);
    assign seq_off = 7'(addr - LSNC_SEQ_FIRST);

    // one read candidate per channel; the reserved upper nibbles read zero
    genvar g;
    generate
        for (g = 0; g < LSNC_NCH; g++) begin : g_chan
            always_comb begin
                case (ch_dec[1:0])
                    2'h0:    ch_byte[g] = st.ph_snap[g][7:0];
                    2'h1:    ch_byte[g] = {4'h0, st.ph_snap[g][11:8]};
                    2'h2:    ch_byte[g] = st.fr_snap[g][7:0];
                    2'h3:    ch_byte[g] = {4'h0, st.fr_snap[g][11:8]};
                    default: ch_byte[g] = 8'h00;
                endcase
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic wr_update;
    logic wr_save;
    logic wr_load;

    assign wr_update = wr && addr == LSNC_UPDATE_ADDR && wdata == LSNC_UPDATE_VALUE;
    assign wr_save   = wr && addr == LSNC_NVM_SAVE_ADDR && wdata[LSNC_TRIG_BIT];
    assign wr_load   = wr && addr == LSNC_NVM_LOAD_ADDR && wdata[LSNC_TRIG_BIT];

    always_comb begin
        logic [LSNC_NEV-1:0] ev_set;
        next_st = st;
        ev_set  = '0;
        next_st.save_go = 1'b0;
        next_st.load_go = 1'b0;

        // snapshot only on update so reads see a coherent set of levels
        if (wr_update) begin
            next_st.ph_snap = phase_level;
            next_st.fr_snap = freq_level;
            ev_set[LSNC_EV_SNAPSHOT] = 1'b1;
        end

        // channel status locations have no write path at all
        if (wr && addr == LSNC_NVM_CTRL_ADDR) begin
            next_st.fast = wdata[LSNC_FAST_BIT];
            next_st.wren = wdata[LSNC_WREN_BIT];
        end
        if (wr && addr == LSNC_NVM_COND_ADDR) begin
            next_st.cond = wdata[3:0];
        end
        if (wr && addr == LSNC_EVT_MASK_ADDR) begin
            next_st.mask = wdata[LSNC_NEV-1:0];
        end
        if (wr && lsnc_in_seq(addr)) begin
            next_st.seq[seq_off] = wdata;
        end

        // trigger bits hold while the engine works and drop on its done pulse
        if (nvm_save_done) begin
            next_st.save_pend = 1'b0;
            ev_set[LSNC_EV_SAVE_DONE] = st.save_pend;
        end
        if (nvm_load_done) begin
            next_st.load_pend = 1'b0;
            ev_set[LSNC_EV_LOAD_DONE] = st.load_pend;
        end
        // a save with writes disabled is refused rather than queued
        if (wr_save && !st.save_pend) begin
            if (st.wren) begin
                next_st.save_pend = 1'b1;
                next_st.save_go   = 1'b1;
            end else begin
                ev_set[LSNC_EV_SAVE_DENY] = 1'b1;
            end
        end
        if (wr_load && !st.load_pend) begin
            next_st.load_pend = 1'b1;
            next_st.load_go   = 1'b1;
        end

        // read data, registered; unmapped and write-only bits read zero
        next_st.rdata = 8'h00;
        if (rd) begin
            if (ch_dec[4]) begin
                next_st.rdata = ch_byte[ch_dec[3:2]];
            end else if (lsnc_in_seq(addr)) begin
                next_st.rdata = st.seq[seq_off];
            end else begin
                case (addr)
                    LSNC_NVM_CTRL_ADDR: next_st.rdata = {6'h00, st.fast, st.wren};
                    LSNC_NVM_COND_ADDR: next_st.rdata = {4'h0, st.cond};
                    LSNC_NVM_SAVE_ADDR: next_st.rdata = {7'h00, st.save_pend};
                    LSNC_NVM_LOAD_ADDR: next_st.rdata = {7'h00, st.load_pend};
                    LSNC_EVT_STAT_ADDR: next_st.rdata = {4'h0, st.evt};
                    LSNC_EVT_MASK_ADDR: next_st.rdata = {4'h0, st.mask};
                    default:            next_st.rdata = 8'h00;
                endcase
            end
        end

        // reading status clears it, but a new event in that cycle survives
        if (rd && addr == LSNC_EVT_STAT_ADDR) begin
            next_st.evt = ev_set;
        end else begin
            next_st.evt = st.evt | ev_set;
        end

        next_st.seq_byte = (seq_index < 7'(LSNC_SEQ_LEN)) ? st.seq[seq_index] : 8'h00;
        next_st.irq      = |(next_st.evt & next_st.mask);
        next_st.ovr      = |next_st.cond;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st      <= '0;
            st.fast <= LSNC_CTRL_RESET[LSNC_FAST_BIT];
            st.wren <= LSNC_CTRL_RESET[LSNC_WREN_BIT];
            st.cond <= LSNC_COND_RESET;
            st.ovr  <= |LSNC_COND_RESET;
            st.mask <= LSNC_MASK_RESET;
            for (int i = 0; i < LSNC_NCH; i++) begin
                st.ph_snap[i] <= LSNC_LEVEL_RESET;
                st.fr_snap[i] <= LSNC_LEVEL_RESET;
            end
            for (int i = 0; i < LSNC_SEQ_LEN; i++) begin
                st.seq[i] <= lsnc_seq_default(7'(i));
            end
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rdata             = st.rdata;
    assign nvm_fast_mode     = st.fast;
    assign nvm_write_en      = st.wren;
    assign nvm_condition     = st.cond;
    assign nvm_cond_override = st.ovr;
    assign nvm_save_start    = st.save_go;
    assign nvm_load_start    = st.load_go;
    assign seq_byte          = st.seq_byte;
    assign irq               = st.irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_snap_follows_update: assert property (@(posedge mclk) disable iff (rst)
        wr_update |=> st.ph_snap == $past(phase_level) && st.fr_snap == $past(freq_level))
        else $error("snapshot not taken on update write");

    a_snap_holds_still: assert property (@(posedge mclk) disable iff (rst)
        !wr_update |=> $stable(st.ph_snap) && $stable(st.fr_snap))
        else $error("status snapshot changed without update");

    a_phase_high_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == LSNC_PH_HIGH_ADDR |=> rdata == {4'h0, st.ph_snap[0][11:8]})
        else $error("phase level high nibble misread");

    a_freq_ch3_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == LSNC_FR_LOW_ADDR + 16'(3) * LSNC_CH_STRIDE |=> rdata == st.fr_snap[3][7:0])
        else $error("channel three frequency level misread");

    a_save_needs_wren: assert property (@(posedge mclk) disable iff (rst)
        nvm_save_start |-> $past(st.wren) && $past(wr_save))
        else $error("save started without write enable");

    a_save_one_pulse: assert property (@(posedge mclk) disable iff (rst)
        nvm_save_start |=> !nvm_save_start && st.save_pend)
        else $error("save start not a single pulse");

    a_load_self_clear: assert property (@(posedge mclk) disable iff (rst)
        st.load_pend && nvm_load_done |=> !st.load_pend)
        else $error("load trigger failed to clear");

    a_cond_override: assert property (@(posedge mclk) disable iff (rst)
        nvm_cond_override == (nvm_condition != 4'h0))
        else $error("condition override mismatch");

    a_rate_select: assert property (@(posedge mclk) disable iff (rst)
        wr && addr == LSNC_NVM_CTRL_ADDR |=> nvm_fast_mode == $past(wdata[LSNC_FAST_BIT]))
        else $error("bus rate select not stored");

    a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == LSNC_NVM_COND_ADDR |=> rdata[7:4] == 4'h0)
        else $error("reserved bits read nonzero");

    // readback of both halves of both levels in channel zero, and of two locations each in channels one to three
    a_phase_low_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == LSNC_PH_LOW_ADDR |=> rdata == st.ph_snap[0][7:0])
        else $error("phase low byte misread");

    a_freq_low_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == LSNC_FR_LOW_ADDR |=> rdata == st.fr_snap[0][7:0])
        else $error("freq low byte misread");

    a_freq_high_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == LSNC_FR_HIGH_ADDR
        |=> rdata == {4'h0, st.fr_snap[0][11:8]})
        else $error("freq high nibble misread");

    a_phase_ch1_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == LSNC_PH_LOW_ADDR + LSNC_CH_STRIDE
        |=> rdata == st.ph_snap[1][7:0])
        else $error("channel one phase misread");

    a_freq_ch1_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == LSNC_FR_HIGH_ADDR + LSNC_CH_STRIDE
        |=> rdata == {4'h0, st.fr_snap[1][11:8]})
        else $error("channel one freq misread");

    a_phase_ch2_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == LSNC_PH_HIGH_ADDR + 16'(2) * LSNC_CH_STRIDE
        |=> rdata == {4'h0, st.ph_snap[2][11:8]})
        else $error("channel two phase misread");

    a_freq_ch2_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == LSNC_FR_LOW_ADDR + 16'(2) * LSNC_CH_STRIDE
        |=> rdata == st.fr_snap[2][7:0])
        else $error("channel two freq misread");

    a_phase_ch3_read: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == LSNC_PH_LOW_ADDR + 16'(3) * LSNC_CH_STRIDE
        |=> rdata == st.ph_snap[3][7:0])
        else $error("channel three phase misread");

    // snapshot only moves on the one update value
    a_status_write_ignored: assert property (@(posedge mclk) disable iff (rst)
        wr && ch_dec[4] |=> $stable(st.ph_snap) && $stable(st.fr_snap))
        else $error("status write changed a level");

    a_update_value_only: assert property (@(posedge mclk) disable iff (rst)
        wr && addr == LSNC_UPDATE_ADDR && wdata != LSNC_UPDATE_VALUE
        |=> $stable(st.ph_snap) && $stable(st.fr_snap))
        else $error("snapshot taken on wrong value");

    // nvm control and trigger handshakes
    a_wren_store: assert property (@(posedge mclk) disable iff (rst)
        wr && addr == LSNC_NVM_CTRL_ADDR
        |=> nvm_write_en == $past(wdata[LSNC_WREN_BIT]))
        else $error("write enable not stored");

    a_save_refused: assert property (@(posedge mclk) disable iff (rst)
        wr_save && !st.wren && !st.save_pend
        |=> !nvm_save_start && st.evt[LSNC_EV_SAVE_DENY])
        else $error("save not refused");

    a_cond_store: assert property (@(posedge mclk) disable iff (rst)
        wr && addr == LSNC_NVM_COND_ADDR |=> nvm_condition == $past(wdata[3:0]))
        else $error("condition not stored");

    a_save_start_go: assert property (@(posedge mclk) disable iff (rst)
        wr_save && st.wren && !st.save_pend |=> nvm_save_start && st.save_pend)
        else $error("save not started");

    a_save_self_clear: assert property (@(posedge mclk) disable iff (rst)
        st.save_pend && nvm_save_done |=> !st.save_pend)
        else $error("save trigger failed to clear");

    a_save_pend_holds: assert property (@(posedge mclk) disable iff (rst)
        st.save_pend && !nvm_save_done |=> st.save_pend)
        else $error("save trigger dropped early");

    a_load_start_go: assert property (@(posedge mclk) disable iff (rst)
        wr_load && !st.load_pend |=> nvm_load_start && st.load_pend)
        else $error("load not started");

    a_load_one_pulse: assert property (@(posedge mclk) disable iff (rst)
        nvm_load_start |=> !nvm_load_start && st.load_pend)
        else $error("load start not a single pulse");

    a_seq_past_end: assert property (@(posedge mclk) disable iff (rst)
        seq_index >= 7'(LSNC_SEQ_LEN) |=> seq_byte == 8'h00)
        else $error("list read past its end");

    a_trig_reserved: assert property (@(posedge mclk) disable iff (rst)
        rd && (addr == LSNC_NVM_SAVE_ADDR || addr == LSNC_NVM_LOAD_ADDR)
        |=> rdata[7:1] == 7'h00)
        else $error("trigger reserved bits nonzero");

endmodule

/* File: lsnc_nvm_model.sv */
// Purpose : behavioural stand-in for the nvm save/load engine and its serial memory
// Assumes : start pulses are one mclk cycle; done answers one cycle long
// Notes   : slow stretches every job so pending bits can be watched
`timescale 1ns/1ps
module lsnc_nvm_model (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic slow,
    input  wire logic nvm_save_start,
    input  wire logic nvm_load_start,
    output logic      nvm_save_done,
    output logic      nvm_load_done
);
    logic       busy;
    logic       kind;
    logic [7:0] cnt;

    // the memory's own write protection is held off here, apart from nvm_write_en,
    // so that every save the block lets through while no load is running completes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy          <= 1'b0;
            kind          <= 1'b0;
            cnt           <= 8'h00;
            nvm_save_done <= 1'b0;
            nvm_load_done <= 1'b0;
        end else begin
            nvm_save_done <= 1'b0;
            nvm_load_done <= 1'b0;
            if (!busy && (nvm_save_start || nvm_load_start)) begin
                busy <= 1'b1;
                kind <= nvm_load_start;
                cnt  <= slow ? 8'h28 : 8'h02;
            end else if (busy) begin
                if (cnt == 8'h00) begin
                    busy          <= 1'b0;
                    nvm_save_done <= !kind;
                    nvm_load_done <= kind;
                end else begin
                    cnt <= cnt - 8'h01;
                end
            end
        end
    end
endmodule

/* File: lock_status_and_nvm_control_regs_tb.sv */
// Purpose : self-checking bench for lsnc_regs
// Assumes : one 25 MHz clock; register port with read data one cycle after rd
// Notes   : a table loop covers reset contents; hand tests cover snapshots and nvm jobs
`timescale 1ns/1ps
module lock_status_and_nvm_control_regs_tb;
    import lsnc_pkg::*;
    logic                                mclk;
    logic                                rst;
    logic [LSNC_AW-1:0]                  addr;
    logic [LSNC_DW-1:0]                  wdata;
    logic                                wr;
    logic                                rd;
    logic [LSNC_DW-1:0]                  rdata;
    logic [LSNC_NCH-1:0][LSNC_LVW-1:0]   phase_level;
    logic [LSNC_NCH-1:0][LSNC_LVW-1:0]   freq_level;
    logic                                nvm_fast_mode;
    logic                                nvm_write_en;
    logic [3:0]                          nvm_condition;
    logic                                nvm_cond_override;
    logic                                nvm_save_start;
    logic                                nvm_load_start;
    logic                                nvm_save_done;
    logic                                nvm_load_done;
    logic [6:0]                          seq_index;
    logic [7:0]                          seq_byte;
    logic                                irq;
    logic                                slow;
    int                                  miscompares;
    int                                  compares;
    int                                  saves;
    int                                  loads;
    logic [7:0]  seqd [0:11] = '{8'h98, 8'h01, 8'h00, 8'hFE, 8'h1F, 8'h01, 8'h00, 8'h08, 8'h02, 8'h00, 8'h80, 8'h91};
    // address beside expected read value after reset
    logic [23:0] rows [0:9]  = '{24'h0E0000, 24'h0E0100, 24'h0E0200, 24'h0E0300, 24'h0E0400, 24'h0E0500,
                                 24'h000F00, 24'h0D2700, 24'h0D8A00, 24'h0E6100};

    lsnc_regs      lsnc_regs_i (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .phase_level(phase_level), .freq_level(freq_level), .nvm_fast_mode(nvm_fast_mode),
        .nvm_write_en(nvm_write_en), .nvm_condition(nvm_condition), .nvm_cond_override(nvm_cond_override),
        .nvm_save_start(nvm_save_start), .nvm_load_start(nvm_load_start), .nvm_save_done(nvm_save_done),
        .nvm_load_done(nvm_load_done), .seq_index(seq_index), .seq_byte(seq_byte), .irq(irq));
    lsnc_nvm_model lsnc_nvm_model_i (.mclk(mclk), .rst(rst), .slow(slow), .nvm_save_start(nvm_save_start),
        .nvm_load_start(nvm_load_start), .nvm_save_done(nvm_save_done), .nvm_load_done(nvm_load_done));

    always #20 mclk = ~mclk;

    always @(posedge mclk) begin
        if (nvm_save_start === 1'b1) saves++;
        if (nvm_load_start === 1'b1) loads++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (miscompares == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wreg(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        @(negedge mclk);
        chk($sformatf("rdata@%h", a), {8'h00, rdata}, {8'h00, e});
    endtask

    // reads back all four channel blocks against the level values given
    task automatic chans(input logic [LSNC_NCH-1:0][LSNC_LVW-1:0] p, input logic [LSNC_NCH-1:0][LSNC_LVW-1:0] f);
        logic [15:0] b;
        for (int c = 0; c < LSNC_NCH; c++) begin
            b = LSNC_PH_LOW_ADDR + 16'(c) * LSNC_CH_STRIDE;
            rdc(b, p[c][7:0]);
            rdc(b + 16'h0001, {4'h0, p[c][11:8]});
            rdc(b + 16'h0002, f[c][7:0]);
            rdc(b + 16'h0003, {4'h0, f[c][11:8]});
        end
    endtask

    task automatic wait_done(input logic ld);
        int n;
        n = 0;
        while ((ld ? nvm_load_done : nvm_save_done) !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk("done_wait", 16'(n < 200), 16'h0001);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [LSNC_NCH-1:0][LSNC_LVW-1:0] p0;
        logic [LSNC_NCH-1:0][LSNC_LVW-1:0] f0;
        mclk = 1'b0; rst = 1'b1; addr = 16'h0000; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
        phase_level = '0; freq_level = '0; seq_index = 7'h00; slow = 1'b0;
        miscompares = 0; compares = 0; saves = 0; loads = 0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk("outs", {9'h000, nvm_fast_mode, nvm_write_en, nvm_condition, irq}, 16'h0000);
        for (int i = 0; i < 10; i++) rdc(rows[i][23:8], rows[i][7:0]);
        for (int i = 0; i < 12; i++) rdc(LSNC_SEQ_FIRST + 16'(i), seqd[i]);
        for (int i = 0; i < 12; i++) begin
            @(posedge mclk);
            seq_index <= 7'(i);
            @(posedge mclk);
            @(negedge mclk);
            chk("seq_byte", {8'h00, seq_byte}, {8'h00, seqd[i]});
        end
        // snapshot: live levels only show after the update write
        for (int c = 0; c < LSNC_NCH; c++) begin
            p0[c] = 12'hC31 + 12'(c) * 12'h101;
            f0[c] = 12'h5A7 + 12'(c) * 12'h202;
        end
        @(posedge mclk);
        phase_level <= p0;
        freq_level  <= f0;
        chans('0, '0);
        wreg(LSNC_UPDATE_ADDR, 8'h02);
        chans('0, '0);
        wreg(LSNC_UPDATE_ADDR, LSNC_UPDATE_VALUE);
        phase_level <= ~p0;
        freq_level  <= ~f0;
        chans(p0, f0);
        for (int c = 0; c < LSNC_NCH; c++)
            for (int k = 0; k < 4; k++) wreg(LSNC_PH_LOW_ADDR + 16'(c) * LSNC_CH_STRIDE + 16'(k), 8'hFF);
        chans(p0, f0);
        rdc(16'h0D2B, 8'h00);
        chk("irq", {15'h0000, irq}, 16'h0000);
        rdc(LSNC_EVT_STAT_ADDR, 8'h08);
        rdc(LSNC_EVT_STAT_ADDR, 8'h00);
        // control fields and reserved bits
        wreg(LSNC_NVM_CTRL_ADDR, 8'hFE);
        rdc(LSNC_NVM_CTRL_ADDR, 8'h02);
        chk("fast_wren", {14'h0000, nvm_fast_mode, nvm_write_en}, 16'h0002);
        wreg(LSNC_NVM_COND_ADDR, 8'hF5);
        rdc(LSNC_NVM_COND_ADDR, 8'h05);
        chk("cond", {11'h000, nvm_cond_override, nvm_condition}, 16'h0015);
        wreg(LSNC_NVM_COND_ADDR, 8'h00);
        @(negedge mclk);
        chk("cond", {11'h000, nvm_cond_override, nvm_condition}, 16'h0000);
        // refused save raises a masked event
        wreg(LSNC_EVT_MASK_ADDR, 8'hF4);
        rdc(LSNC_EVT_MASK_ADDR, 8'h04);
        wreg(LSNC_NVM_SAVE_ADDR, 8'h01);
        rdc(LSNC_NVM_SAVE_ADDR, 8'h00);
        chk("irq", {15'h0000, irq}, 16'h0001);
        chk("saves", 16'(saves), 16'h0000);
        rdc(LSNC_EVT_STAT_ADDR, 8'h04);
        @(negedge mclk);
        chk("irq", {15'h0000, irq}, 16'h0000);
        // slow save, second trigger while pending is ignored
        wreg(LSNC_NVM_CTRL_ADDR, 8'h01);
        slow <= 1'b1;
        wreg(LSNC_NVM_SAVE_ADDR, 8'h01);
        rdc(LSNC_NVM_SAVE_ADDR, 8'h01);
        wreg(LSNC_NVM_SAVE_ADDR, 8'h01);
        chk("saves", 16'(saves), 16'h0001);
        wait_done(1'b0);
        rdc(LSNC_NVM_SAVE_ADDR, 8'h00);
        rdc(LSNC_EVT_STAT_ADDR, 8'h01);
        slow <= 1'b0;
        wreg(LSNC_NVM_LOAD_ADDR, 8'hFF);
        wait_done(1'b1);
        rdc(LSNC_NVM_LOAD_ADDR, 8'h00);
        chk("loads", 16'(loads), 16'h0001);
        rdc(LSNC_EVT_STAT_ADDR, 8'h02);
        // instruction list is writable storage
        wreg(LSNC_SEQ_LAST, 8'h5A);
        rdc(LSNC_SEQ_LAST, 8'h5A);
        @(posedge mclk);
        seq_index <= 7'h51;
        @(posedge mclk);
        seq_index <= 7'h52;
        @(negedge mclk);
        chk("seq_byte", {8'h00, seq_byte}, 16'h005A);
        @(negedge mclk);
        chk("seq_byte", {8'h00, seq_byte}, 16'h0000);
        // second reset in mid-run
        wreg(LSNC_NVM_CTRL_ADDR, 8'h03);
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        rdc(LSNC_NVM_CTRL_ADDR, 8'h00);
        rdc(LSNC_SEQ_LAST, 8'h00);
        chans('0, '0);
        end_sim();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        end_sim();
    end
endmodule
